// ---- src/mtcsr_map.svh ----
// constants for the machine trap csr block: csr numbers, field positions, reset values
// assumes it is included by the design modules and the props checker by bare name
//
// Functional notes
// - event selector csrs 0x323..0x33f read zero and drop writes
// - on exception save current pc to exception pc, redirect fetch to handler
// - machine return loads pc from exception pc
// - exception pc bits 31:1 writable, bit 0 reads zero
// - cause top bit set for interrupt, clear for synchronous exception
// - basic mode cause keeps trap code 10:0, bits 30:11 read zero
// - clic mode vectoring flag set at vectoring start, cleared on success
// - clic previous privilege takes only 0 or 3, mirrors status field
// - clic previous interrupt enable shares storage with status bit
// - clic cause holds writable previous interrupt level in 23:16
// - trap value reads zero always, writes ignored, never recorded
// - basic mode pending bits 31:16 read-only copies of request lines
// - basic mode pending 11, 7, 3 copy request lines; other low bits zero
// - clic mode pending register reads all zero
// - next-interrupt access illegal unless read-set x0, immediate set or clear
// - next-interrupt immediate set with immediate bit 0, 2 or 4 is illegal
// - threshold held in low eight bits, 31:8 read zero
// - threshold implements top bits only, unimplemented low bits read one
// - privilege-swap scratch: only swap with nonzero rd and rs1 is legal
// - next-interrupt, threshold, privilege-swap exist only with clic option
`ifndef MTCSR_MAP_SVH
`define MTCSR_MAP_SVH
// csr numbers
`define MTCSR_ADDR_EVSEL_LO   12'h323
`define MTCSR_ADDR_EVSEL_HI   12'h33f
`define MTCSR_ADDR_SCRATCH    12'h340
`define MTCSR_ADDR_EPC        12'h341
`define MTCSR_ADDR_CAUSE      12'h342
`define MTCSR_ADDR_TVAL       12'h343
`define MTCSR_ADDR_PENDING    12'h344
`define MTCSR_ADDR_NXTI       12'h345
`define MTCSR_ADDR_THRESH     12'h347
`define MTCSR_ADDR_SWAPSCR    12'h348
// cause field positions
`define MTCSR_CAUSE_IRQ_BIT   31
`define MTCSR_CAUSE_HV_BIT    30
`define MTCSR_CAUSE_PP_HI     29
`define MTCSR_CAUSE_PP_LO     28
`define MTCSR_CAUSE_PIE_BIT   27
`define MTCSR_CAUSE_PIL_HI    23
`define MTCSR_CAUSE_PIL_LO    16
`define MTCSR_CAUSE_CODE_HI   10
`define MTCSR_CAUSE_CODEC_HI  11
// pending line positions
`define MTCSR_PEND_EXT_BIT    11
`define MTCSR_PEND_TMR_BIT    7
`define MTCSR_PEND_SW_BIT     3
`define MTCSR_PEND_FAST_LO    16
// privilege encodings
`define MTCSR_PRIV_USER       2'h0
`define MTCSR_PRIV_MACHINE    2'h3
// reset values
`define MTCSR_RST_ZERO        32'h0000_0000
`define MTCSR_RST_CAUSE_CLIC  32'h3000_0000
`define MTCSR_RST_PP          2'h3
`endif

// ---- src/mtcsr_pkg.sv ----
// types shared by the machine trap csr block
// assumes nothing beyond a systemverilog compiler
package mtcsr_pkg;
  // csr instruction forms as decoded by the pipeline
  typedef enum logic [2:0] {
    MTCSR_OP_RW  = 3'h1,
    MTCSR_OP_RS  = 3'h2,
    MTCSR_OP_RC  = 3'h3,
    MTCSR_OP_RWI = 3'h5,
    MTCSR_OP_RSI = 3'h6,
    MTCSR_OP_RCI = 3'h7
  } mtcsr_op_e;
  typedef logic [31:0] mtcsr_word_t;
endpackage : mtcsr_pkg

// ---- src/mtcsr_access_check.sv ----
// legality check for csr instruction forms on the clic-only registers
// assumes the decode fields are stable while csrValid is high
`include "mtcsr_map.svh"
module mtcsr_access_check #(
  parameter bit ClicOption = 1'b1  // clic option built in
) (
  input  wire logic              csrValid,   // csr access this cycle
  input  wire logic [11:0]       csrAddr,    // csr number
  input  wire mtcsr_pkg::mtcsr_op_e csrOp,   // instruction form
  input  wire logic [4:0]        rs1Idx,     // source index or immediate
  input  wire logic [4:0]        rdIdx,      // destination index
  output logic                   csrIllegal, // access is illegal
  output logic                   csrMapped   // address decodes to this block
);
  import mtcsr_pkg::*;

  logic isNxti;
  logic isThresh;
  logic isSwap;
  logic isEvsel;
  logic isBase;
  logic nxtiOk;
  logic swapOk;

  // address decode; clic-only csrs vanish without the option
  always_comb begin
    isNxti   = ClicOption && (csrAddr == `MTCSR_ADDR_NXTI);
    isThresh = ClicOption && (csrAddr == `MTCSR_ADDR_THRESH);
    isSwap   = ClicOption && (csrAddr == `MTCSR_ADDR_SWAPSCR);
    isEvsel  = (csrAddr >= `MTCSR_ADDR_EVSEL_LO) && (csrAddr <= `MTCSR_ADDR_EVSEL_HI);
    isBase   = (csrAddr >= `MTCSR_ADDR_SCRATCH) && (csrAddr <= `MTCSR_ADDR_PENDING);
    csrMapped = isNxti || isThresh || isSwap || isEvsel || isBase;
  end

  // form checks; unmapped numbers are left to the main decoder
  always_comb begin
    nxtiOk = ((csrOp == MTCSR_OP_RS) && (rs1Idx == 5'h00))
          || ((csrOp == MTCSR_OP_RSI) && !rs1Idx[0] && !rs1Idx[2] && !rs1Idx[4])
          || (csrOp == MTCSR_OP_RCI);
    swapOk = (csrOp == MTCSR_OP_RW) && (rs1Idx != 5'h00) && (rdIdx != 5'h00);
    csrIllegal = csrValid && ((isNxti && !nxtiOk) || (isSwap && !swapOk));
  end
endmodule // mtcsr_access_check

// ---- src/mtcsr_trap_regs.sv ----
// machine trap csrs: scratch, exception pc, cause, trap value, pending view,
// next-interrupt, threshold and privilege-swap scratch
// assumes the pipeline presents one csr access per cycle and that trap,
// return and vectoring events are single-cycle pulses on mclk
`include "mtcsr_map.svh"
module mtcsr_trap_regs #(
  parameter bit         ClicOption   = 1'b1, // clic option built in
  parameter int unsigned ThresholdBits = 8   // implemented threshold bits, 0..8
) (
  input  wire logic                  mclk,          // core clock
  input  wire logic                  reset_n,       // async reset, active low
  input  wire logic                  csrValid,      // csr instruction executes
  input  wire logic [11:0]           csrAddr,       // csr number
  input  wire mtcsr_pkg::mtcsr_op_e  csrOp,         // instruction form
  input  wire logic [4:0]            rs1Idx,        // source index or immediate
  input  wire logic [4:0]            rdIdx,         // destination index
  input  wire mtcsr_pkg::mtcsr_word_t csrWdata,     // source operand or zero-extended immediate
  output mtcsr_pkg::mtcsr_word_t     csrRdata,      // read data, registered
  output logic                       csrIllegal,    // illegal instruction raise
  output logic                       csrRdValid,    // read data valid pulse
  input  wire logic                  trapTake,      // exception or interrupt taken
  input  wire logic                  trapIsIrq,     // taken trap is an interrupt
  input  wire logic [11:0]           trapCode,      // cause code of taken trap
  input  wire mtcsr_pkg::mtcsr_word_t trapPc,       // pc of trapping instruction
  input  wire mtcsr_pkg::mtcsr_word_t handlerAddr,  // handler address from vector logic
  input  wire logic                  mretExec,      // machine return executes
  input  wire logic                  hvStart,       // hardware vectoring starts
  input  wire logic                  hvDone,        // hardware vectoring completed
  input  wire logic [31:0]           irqLines,      // interrupt request lines
  output logic                       fetchRedirect, // fetch redirect pulse
  output mtcsr_pkg::mtcsr_word_t     fetchTarget,   // redirect target, registered
  output logic [1:0]                 prevPrivilege, // status previous privilege view
  output logic                       prevIntEnable, // status previous interrupt enable view
  output logic [7:0]                 thresholdLevel // current interrupt level threshold
);
  import mtcsr_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  mtcsr_word_t scratchQ,  scratchD;
  mtcsr_word_t epcQ,      epcD;
  mtcsr_word_t swapScrQ,  swapScrD;
  logic        causeIrqQ, causeIrqD;
  logic        hvFlagQ,   hvFlagD;
  logic [1:0]  ppQ,       ppD;
  logic        pieQ,      pieD;
  logic [7:0]  pilQ,      pilD;
  logic [11:0] codeQ,     codeD;
  logic [7:0]  threshQ,   threshD;
  mtcsr_word_t rdataQ,    rdataD;
  logic        rdValidQ,  rdValidD;
  logic        redirQ,    redirD;
  mtcsr_word_t targetQ,   targetD;

  logic        illegal;
  logic        mapped;
  logic        doAccess;
  logic        doWrite;
  mtcsr_word_t oldVal;
  mtcsr_word_t newVal;
  mtcsr_word_t pendView;
  mtcsr_word_t causeView;
  logic [7:0]  threshMask;

  // ==========================================================================
  // legality
  // ==========================================================================
  mtcsr_access_check #(
    .ClicOption (ClicOption)
  ) u_check (
    .csrValid   (csrValid),
    .csrAddr    (csrAddr),
    .csrOp      (csrOp),
    .rs1Idx     (rs1Idx),
    .rdIdx      (rdIdx),
    .csrIllegal (illegal),
    .csrMapped  (mapped)
  );

  assign csrIllegal = illegal;
  assign doAccess   = csrValid && mapped && !illegal;

  // ==========================================================================
  // read views
  // ==========================================================================
  // low threshold bits past the implemented count are forced to one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      threshMask[i] = (i < (8 - ThresholdBits));
    end
  end

  // pending view is pure wiring of the request lines, no storage
  generate
    for (genvar b = 0; b < 32; b++) begin : g_pend
      if (b >= `MTCSR_PEND_FAST_LO || b == `MTCSR_PEND_EXT_BIT ||
          b == `MTCSR_PEND_TMR_BIT || b == `MTCSR_PEND_SW_BIT) begin : g_live
        assign pendView[b] = ClicOption ? 1'b0 : irqLines[b];
      end else begin : g_zero
        assign pendView[b] = 1'b0;
      end
    end
  endgenerate

  // cause layout differs by build option
  always_comb begin
    causeView = `MTCSR_RST_ZERO;
    causeView[`MTCSR_CAUSE_IRQ_BIT] = causeIrqQ;
    if (ClicOption) begin
      causeView[`MTCSR_CAUSE_HV_BIT] = hvFlagQ;
      causeView[`MTCSR_CAUSE_PP_HI:`MTCSR_CAUSE_PP_LO] = ppQ;
      causeView[`MTCSR_CAUSE_PIE_BIT] = pieQ;
      causeView[`MTCSR_CAUSE_PIL_HI:`MTCSR_CAUSE_PIL_LO] = pilQ;
      causeView[`MTCSR_CAUSE_CODEC_HI:0] = codeQ;
    end else begin
      causeView[`MTCSR_CAUSE_CODE_HI:0] = codeQ[10:0];
    end
  end

  // old value of the addressed csr
  always_comb begin
    oldVal = `MTCSR_RST_ZERO; // event selectors, trap value and unmapped read zero
    unique case (csrAddr)
      `MTCSR_ADDR_SCRATCH: oldVal = scratchQ;
      `MTCSR_ADDR_EPC:     oldVal = {epcQ[31:1], 1'b0};
      `MTCSR_ADDR_CAUSE:   oldVal = causeView;
      `MTCSR_ADDR_TVAL:    oldVal = `MTCSR_RST_ZERO;
      `MTCSR_ADDR_PENDING: oldVal = pendView;
      `MTCSR_ADDR_THRESH:  oldVal = {24'h000000, threshQ | threshMask};
      `MTCSR_ADDR_SWAPSCR: oldVal = swapScrQ;
      default:             oldVal = `MTCSR_RST_ZERO;
    endcase
  end

  // read-modify-write value
  always_comb begin
    newVal  = oldVal;
    doWrite = doAccess;
    unique case (csrOp)
      MTCSR_OP_RW,  MTCSR_OP_RWI: newVal = csrWdata;
      MTCSR_OP_RS,  MTCSR_OP_RSI: begin
        newVal  = oldVal | csrWdata;
        doWrite = doAccess && (rs1Idx != 5'h00);
      end
      MTCSR_OP_RC,  MTCSR_OP_RCI: begin
        newVal  = oldVal & ~csrWdata;
        doWrite = doAccess && (rs1Idx != 5'h00);
      end
      default: doWrite = 1'b0;
    endcase
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    scratchD  = scratchQ;
    epcD      = epcQ;
    swapScrD  = swapScrQ;
    causeIrqD = causeIrqQ;
    hvFlagD   = hvFlagQ;
    ppD       = ppQ;
    pieD      = pieQ;
    pilD      = pilQ;
    codeD     = codeQ;
    threshD   = threshQ;
    rdataD    = oldVal;
    rdValidD  = doAccess;
    redirD    = 1'b0;
    targetD   = targetQ;

    // software writes
    if (doWrite) begin
      unique case (csrAddr)
        `MTCSR_ADDR_SCRATCH: scratchD = newVal;
        `MTCSR_ADDR_EPC:     epcD = {newVal[31:1], 1'b0};
        `MTCSR_ADDR_CAUSE: begin
          causeIrqD = newVal[`MTCSR_CAUSE_IRQ_BIT];
          if (ClicOption) begin
            hvFlagD = newVal[`MTCSR_CAUSE_HV_BIT];
            // only user or machine kept; other codes leave the field as is
            if (newVal[`MTCSR_CAUSE_PP_HI:`MTCSR_CAUSE_PP_LO] == `MTCSR_PRIV_USER ||
                newVal[`MTCSR_CAUSE_PP_HI:`MTCSR_CAUSE_PP_LO] == `MTCSR_PRIV_MACHINE) begin
              ppD = newVal[`MTCSR_CAUSE_PP_HI:`MTCSR_CAUSE_PP_LO];
            end
            pieD  = newVal[`MTCSR_CAUSE_PIE_BIT];
            pilD  = newVal[`MTCSR_CAUSE_PIL_HI:`MTCSR_CAUSE_PIL_LO];
            codeD = newVal[`MTCSR_CAUSE_CODEC_HI:0];
          end else begin
            codeD = {1'b0, newVal[`MTCSR_CAUSE_CODE_HI:0]};
          end
        end
        `MTCSR_ADDR_THRESH:  threshD = newVal[7:0] | threshMask;
        `MTCSR_ADDR_SWAPSCR: begin
          // swap only across a privilege change; in machine mode it is a read
          if (ppQ != `MTCSR_PRIV_MACHINE) begin
            swapScrD = newVal;
          end
        end
        default: ;
      endcase
    end

    // hardware events win over a same-cycle software write
    if (ClicOption && hvStart) begin
      hvFlagD = 1'b1;
    end else if (ClicOption && hvDone) begin
      hvFlagD = 1'b0;
    end
    if (trapTake) begin
      epcD      = {trapPc[31:1], 1'b0};
      causeIrqD = trapIsIrq;
      codeD     = ClicOption ? trapCode : {1'b0, trapCode[10:0]};
      redirD    = 1'b1;
      targetD   = handlerAddr;
    end else if (mretExec) begin
      redirD  = 1'b1;
      targetD = {epcQ[31:1], 1'b0};
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scratchQ  <= `MTCSR_RST_ZERO;
      epcQ      <= `MTCSR_RST_ZERO;
      swapScrQ  <= `MTCSR_RST_ZERO;
      causeIrqQ <= 1'b0;
      hvFlagQ   <= 1'b0;
      ppQ       <= ClicOption ? `MTCSR_RST_PP : 2'h0; // clic reset shows 0x3000_0000
      pieQ      <= 1'b0;
      pilQ      <= 8'h00;
      codeQ     <= 12'h000;
      threshQ   <= 8'h00;
      rdataQ    <= `MTCSR_RST_ZERO;
      rdValidQ  <= 1'b0;
      redirQ    <= 1'b0;
      targetQ   <= `MTCSR_RST_ZERO;
    end else begin
      scratchQ  <= scratchD;
      epcQ      <= epcD;
      swapScrQ  <= swapScrD;
      causeIrqQ <= causeIrqD;
      hvFlagQ   <= hvFlagD;
      ppQ       <= ppD;
      pieQ      <= pieD;
      pilQ      <= pilD;
      codeQ     <= codeD;
      threshQ   <= threshD;
      rdataQ    <= rdataD;
      rdValidQ  <= rdValidD;
      redirQ    <= redirD;
      targetQ   <= targetD;
    end
  end

  // outputs straight from flops
  assign csrRdata       = rdataQ;
  assign csrRdValid     = rdValidQ;
  assign fetchRedirect  = redirQ;
  assign fetchTarget    = targetQ;
  assign prevPrivilege  = ppQ;
  assign prevIntEnable  = pieQ;
  assign thresholdLevel = threshQ | threshMask;
endmodule // mtcsr_trap_regs

// ---- verif/mtcsr_trap_props.sv ----
// concurrent checks on the ports of the machine trap csr block
// assumes one clock mclk and reset_n; bound onto every mtcsr_trap_regs
`include "mtcsr_map.svh"
module mtcsr_trap_props #(
  parameter bit          ClicOption    = 1'b1, // clic option built in
  parameter int unsigned ThresholdBits = 8     // implemented threshold bits
) (
  input wire logic                   mclk,           // core clock
  input wire logic                   reset_n,        // async reset, active low
  input wire logic                   csrValid,       // csr access
  input wire logic [11:0]            csrAddr,        // csr number
  input wire mtcsr_pkg::mtcsr_op_e   csrOp,          // instruction form
  input wire logic [4:0]             rs1Idx,         // source index
  input wire logic [4:0]             rdIdx,          // destination index
  input wire mtcsr_pkg::mtcsr_word_t csrRdata,       // read data
  input wire logic                   csrIllegal,     // illegal flag
  input wire logic                   csrRdValid,     // read data valid
  input wire logic                   trapTake,       // trap taken
  input wire mtcsr_pkg::mtcsr_word_t handlerAddr,    // handler address
  input wire logic                   mretExec,       // machine return
  input wire logic                   fetchRedirect,  // redirect pulse
  input wire mtcsr_pkg::mtcsr_word_t fetchTarget,    // redirect target
  input wire logic [1:0]             prevPrivilege,  // status privilege view
  input wire logic [7:0]             thresholdLevel  // threshold view
);
  import mtcsr_pkg::*;
  localparam logic [7:0] LowMask = 8'hff >> ThresholdBits;
  // =====================================================
  // access decode helpers
  logic nxtiAcc;
  logic swapAcc;
  assign nxtiAcc = csrValid && csrAddr == `MTCSR_ADDR_NXTI && ClicOption;
  assign swapAcc = csrValid && csrAddr == `MTCSR_ADDR_SWAPSCR && ClicOption;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // =====================================================
  // assertions
  chk_trap_redirect: assert property (trapTake |=> fetchRedirect && fetchTarget == $past(handlerAddr))
    else $error("trap redirect target wrong");
  chk_mret_even: assert property (mretExec && !trapTake |=> fetchRedirect && !fetchTarget[0])
    else $error("return redirect wrong");
  chk_nxti_form: assert property (nxtiAcc && !((csrOp == MTCSR_OP_RS && rs1Idx == 5'h00)
    || csrOp == MTCSR_OP_RSI || csrOp == MTCSR_OP_RCI) |-> csrIllegal) else $error("bad next form accepted");
  chk_nxti_imm: assert property (nxtiAcc && csrOp == MTCSR_OP_RSI && (rs1Idx & 5'h15) != 5'h00 |-> csrIllegal)
    else $error("reserved immediate accepted");
  chk_swap_form: assert property (swapAcc && (csrOp != MTCSR_OP_RW || rdIdx == 5'h00 || rs1Idx == 5'h00)
    |-> csrIllegal) else $error("bad swap form accepted");
  chk_refused_quiet: assert property (csrIllegal |=> !csrRdValid)
    else $error("refused access answered");
  chk_zero_regs: assert property (csrValid && ((csrAddr >= `MTCSR_ADDR_EVSEL_LO && csrAddr <= `MTCSR_ADDR_EVSEL_HI)
    || csrAddr == `MTCSR_ADDR_TVAL) |=> csrRdValid && csrRdata == 32'h0) else $error("zero register read nonzero");
  chk_thresh_hold: assert property (!(csrValid && csrAddr == `MTCSR_ADDR_THRESH) |=> $stable(thresholdLevel))
    else $error("threshold changed without write");
  chk_thresh_ones: assert property (csrValid && csrAddr == `MTCSR_ADDR_THRESH && csrOp == MTCSR_OP_RW
    && !csrIllegal |=> (thresholdLevel & LowMask) == LowMask) else $error("threshold low bits not one");
  chk_priv_legal: assert property (prevPrivilege == 2'h0 || prevPrivilege == 2'h3)
    else $error("previous privilege illegal");
endmodule // mtcsr_trap_props
bind mtcsr_trap_regs mtcsr_trap_props #(.ClicOption(ClicOption), .ThresholdBits(ThresholdBits)) i_mtcsr_trap_props (
  .mclk(mclk), .reset_n(reset_n), .csrValid(csrValid), .csrAddr(csrAddr), .csrOp(csrOp), .rs1Idx(rs1Idx),
  .rdIdx(rdIdx), .csrRdata(csrRdata), .csrIllegal(csrIllegal), .csrRdValid(csrRdValid), .trapTake(trapTake),
  .handlerAddr(handlerAddr), .mretExec(mretExec), .fetchRedirect(fetchRedirect), .fetchTarget(fetchTarget),
  .prevPrivilege(prevPrivilege), .thresholdLevel(thresholdLevel));

// ---- verif/mtcsr_irq_model.sv ----
// interrupt request source standing in for the core's request wiring
// assumes the block samples the lines on the rising edge of mclk
module mtcsr_irq_model (
  input  wire logic        mclk,             // core clock
  input  wire logic [31:0] level,            // requested line levels
  output logic      [31:0] irqLines = 32'h0  // lines toward the block
);
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================================
  // lines move on the falling edge so no sample races a transition
  always @(negedge mclk) begin
    irqLines <= level;
  end
endmodule // mtcsr_irq_model

// ---- verif/tb.sv ----
// self-checking bench for the machine trap csr block, clic and basic builds
// assumes the props checker is bound and the irq model drives the lines
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mtcsr_pkg::*;
  // =====================================================
  // stimulus and observed signals
  logic        mclk = 1'b0, reset_n = 1'b0, csrValid = 1'b0, trapTake = 1'b0, trapIsIrq = 1'b0;
  logic        mretExec = 1'b0, hvStart = 1'b0, hvDone = 1'b0, csrIllegal, csrRdValid, fetchRedirect;
  logic        prevIntEnable, ill, rdv, illB, illBasic, rdvB;
  logic [11:0] csrAddr = 12'h000, trapCode = 12'h000;
  logic [4:0]  rs1Idx = 5'h00, rdIdx = 5'h00;
  logic [1:0]  prevPrivilege;
  logic [7:0]  thresholdLevel;
  logic [31:0] irqLines;
  mtcsr_op_e   csrOp = MTCSR_OP_RS;
  mtcsr_word_t csrWdata = 32'h0, trapPc = 32'h0, handlerAddr = 32'h0, irqLevel = 32'h0;
  mtcsr_word_t csrRdata, fetchTarget, rd, rdB;
  int          n_fail = 0, n_checks = 0;
  always #25 mclk = ~mclk;
  // low three threshold bits unimplemented so the forced ones show
  mtcsr_trap_regs #(.ClicOption(1'b1), .ThresholdBits(5)) i_mtcsr_trap_regs (.mclk(mclk), .reset_n(reset_n),
    .csrValid(csrValid), .csrAddr(csrAddr), .csrOp(csrOp), .rs1Idx(rs1Idx), .rdIdx(rdIdx), .csrWdata(csrWdata),
    .csrRdata(csrRdata), .csrIllegal(csrIllegal), .csrRdValid(csrRdValid), .trapTake(trapTake),
    .trapIsIrq(trapIsIrq), .trapCode(trapCode), .trapPc(trapPc), .handlerAddr(handlerAddr), .mretExec(mretExec),
    .hvStart(hvStart), .hvDone(hvDone), .irqLines(irqLines), .fetchRedirect(fetchRedirect),
    .fetchTarget(fetchTarget), .prevPrivilege(prevPrivilege), .prevIntEnable(prevIntEnable),
    .thresholdLevel(thresholdLevel));
  mtcsr_irq_model i_mtcsr_irq_model (.mclk(mclk), .level(irqLevel), .irqLines(irqLines));
  // basic build on the same stimulus; only its csr answers are watched
  mtcsr_trap_regs #(.ClicOption(1'b0)) i_mtcsr_trap_regs_basic (.mclk(mclk), .reset_n(reset_n),
    .csrValid(csrValid), .csrAddr(csrAddr), .csrOp(csrOp), .rs1Idx(rs1Idx), .rdIdx(rdIdx), .csrWdata(csrWdata),
    .csrRdata(rdB), .csrIllegal(illBasic), .csrRdValid(rdvB), .trapTake(trapTake),
    .trapIsIrq(trapIsIrq), .trapCode(trapCode), .trapPc(trapPc), .handlerAddr(handlerAddr), .mretExec(mretExec),
    .hvStart(hvStart), .hvDone(hvDone), .irqLines(irqLines), .fetchRedirect(), .fetchTarget(), .prevPrivilege(),
    .prevIntEnable(), .thresholdLevel());
  // =====================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one access: illegal flag sampled late in its cycle, answer one cycle on
  task automatic csr(input logic [11:0] a, input mtcsr_op_e op, input logic [4:0] s, input logic [4:0] d,
                     input mtcsr_word_t w);
    @(negedge mclk);
    csrValid = 1'b1;
    csrAddr = a;
    csrOp = op;
    rs1Idx = s;
    rdIdx = d;
    csrWdata = w;
    #20 {ill, illB} = {csrIllegal, illBasic};
    @(negedge mclk);
    csrValid = 1'b0;
    rdv = csrRdValid;
    rd = csrRdata;
  endtask
  task automatic wr(input logic [11:0] a, input mtcsr_word_t w);
    csr(a, MTCSR_OP_RW, 5'h01, 5'h01, w);
  endtask
  task automatic rd_chk(input logic [11:0] a, input mtcsr_word_t exp);
    csr(a, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check(rd, exp);
    check(rdv, 1'b1);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  // =====================================================
  // scenarios
  task automatic t_cause();
    rd_chk(12'h340, 32'h0);
    rd_chk(12'h342, 32'h3000_0000);
    wr(12'h342, 32'h2000_0000);
    rd_chk(12'h342, 32'h3000_0000);
    wr(12'h342, 32'h08a5_0000);
    rd_chk(12'h342, 32'h08a5_0000);
    check(prevPrivilege, 2'h0);
    check(prevIntEnable, 1'b1);
    pulse(hvStart);
    rd_chk(12'h342, 32'h48a5_0000);
    pulse(hvDone);
    rd_chk(12'h342, 32'h08a5_0000);
  endtask
  task automatic t_swap();
    csr(12'h348, MTCSR_OP_RW, 5'h02, 5'h01, 32'h0000_00a1);
    check(rd, 32'h0);
    csr(12'h348, MTCSR_OP_RW, 5'h02, 5'h01, 32'h0000_00b2);
    check(rd, 32'h0000_00a1);
    csr(12'h348, MTCSR_OP_RS, 5'h02, 5'h01, 32'h0);
    check({ill, rdv}, 2'b10);
    csr(12'h348, MTCSR_OP_RW, 5'h00, 5'h01, 32'h0);
    check({ill, rdv}, 2'b10);
    csr(12'h348, MTCSR_OP_RW, 5'h02, 5'h00, 32'h0000_00e5);
    check({ill, rdv}, 2'b10);
    wr(12'h342, 32'h3000_0000);
    csr(12'h348, MTCSR_OP_RW, 5'h02, 5'h01, 32'h0000_00c3);
    check(rd, 32'h0000_00b2);
    wr(12'h342, 32'h0);
    csr(12'h348, MTCSR_OP_RW, 5'h02, 5'h01, 32'h0000_00d4);
    check(rd, 32'h0000_00b2);
  endtask
  task automatic t_nxti();
    mtcsr_op_e  ops[10] = '{MTCSR_OP_RS, MTCSR_OP_RSI, MTCSR_OP_RCI, MTCSR_OP_RW, MTCSR_OP_RS, MTCSR_OP_RC,
                            MTCSR_OP_RWI, MTCSR_OP_RSI, MTCSR_OP_RSI, MTCSR_OP_RSI};
    logic [4:0] srcs[10] = '{5'h00, 5'h08, 5'h1f, 5'h01, 5'h01, 5'h01, 5'h00, 5'h01, 5'h04, 5'h10};
    logic       bad[10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 10; i++) begin
      csr(12'h345, ops[i], srcs[i], 5'h01, {27'h0, srcs[i]});
      check({ill, rdv}, {bad[i], ~bad[i]});
    end
  endtask
  task automatic t_thresh();
    rd_chk(12'h347, 32'h0000_0007);
    wr(12'h347, 32'h0);
    rd_chk(12'h347, 32'h0000_0007);
    check(thresholdLevel, 8'h07);
    wr(12'h347, 32'hffff_ffff);
    rd_chk(12'h347, 32'h0000_00ff);
    wr(12'h347, 32'h0000_0040);
    rd_chk(12'h347, 32'h0000_0047);
  endtask
  task automatic t_zero();
    for (int a = 12'h323; a <= 12'h33f; a++) begin
      wr(a[11:0], 32'hffff_ffff);
      rd_chk(a[11:0], 32'h0);
    end
    wr(12'h343, 32'hffff_ffff);
    rd_chk(12'h343, 32'h0);
    wr(12'h341, 32'h0000_1235);
    rd_chk(12'h341, 32'h0000_1234);
    irqLevel = 32'hffff_ffff;
    wr(12'h344, 32'hffff_ffff);
    rd_chk(12'h344, 32'h0);
    csr(12'h346, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check({ill, rdv}, 2'b00);
  endtask
  task automatic t_basic();
    irqLevel = 32'ha5a5_ffff;
    csr(12'h344, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check(rdB, 32'ha5a5_0888);
    check(rd, 32'h0);
    wr(12'h342, 32'hffff_ffff);
    csr(12'h342, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check(rdB, 32'h8000_07ff);
    csr(12'h348, MTCSR_OP_RS, 5'h02, 5'h01, 32'h0);
    check({illB, rdvB}, 2'b00);
  endtask
  task automatic t_trap();
    trapPc = 32'h0000_8001;
    handlerAddr = 32'h0000_4000;
    trapIsIrq = 1'b1;
    trapCode = 12'h00b;
    @(negedge mclk);
    trapTake = 1'b1;
    mretExec = 1'b1;
    @(negedge mclk);
    trapTake = 1'b0;
    mretExec = 1'b0;
    check({fetchRedirect, fetchTarget}, {1'b1, 32'h0000_4000});
    rd_chk(12'h341, 32'h0000_8000);
    csr(12'h342, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check(rd[31], 1'b1);
    check(rd[11:0], 12'h00b);
    pulse(mretExec);
    check({fetchRedirect, fetchTarget}, {1'b1, 32'h0000_8000});
    trapIsIrq = 1'b0;
    trapCode = 12'h002;
    pulse(trapTake);
    csr(12'h342, MTCSR_OP_RS, 5'h00, 5'h01, 32'h0);
    check({rd[31], rd[11:0]}, 13'h0002);
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    t_cause();
    t_swap();
    t_nxti();
    t_thresh();
    t_zero();
    t_basic();
    t_trap();
    end_sim();
  end
endmodule // tb
